// *** pkg/aasw_defs.svh ***
`ifndef AASW_DEFS_SVH
`define AASW_DEFS_SVH

// register indices; byte address is four times the index
`define AASW_IDX_AST     3'h1
`define AASW_IDX_WUP     3'h2
`define AASW_IDX_WLO     3'h3
`define AASW_IDX_STAT    3'h4
`define AASW_ADR_AST     ({`AASW_IDX_AST, 2'b00})
`define AASW_ADR_WUP     ({`AASW_IDX_WUP, 2'b00})
`define AASW_ADR_WLO     ({`AASW_IDX_WLO, 2'b00})
`define AASW_ADR_STAT    ({`AASW_IDX_STAT, 2'b00})

// reset values
`define AASW_RST_AST     8'hff
`define AASW_RST_WUP     8'hff
`define AASW_RST_WLO     8'hff

// address layout: eight areas of 2 Mbyte in a 24-bit space
`define AASW_ADDR_W      24
`define AASW_AREA_LSB    21
`define AASW_AREA_MSB    23

// status register fields
`define AASW_ST_BUSY     0
`define AASW_ST_ADV      1
`define AASW_ST_AREA_LSB 2
`define AASW_ST_AREA_MSB 4
`define AASW_ST_THREE    5
`define AASW_ST_WAIT_LSB 6
`define AASW_ST_WAIT_MSB 7

// fixed state count of an internal access
`define AASW_INT_STATES  2'h2

// pin synchroniser reset levels {mode, manual_n, standby_n, wait_n}
`define AASW_PIN_RST     4'h7

`endif

// *** pkg/aasw_pkg.sv ***
package aasw_pkg;

  typedef enum logic [2:0] {
    AASW_IDLE = 3'b000,
    AASW_T1   = 3'b001,
    AASW_T2   = 3'b010,
    AASW_TW   = 3'b011,
    AASW_T3   = 3'b100,
    AASW_TI   = 3'b101
  } aasw_state_t;

  typedef logic [2:0] aasw_area_t;

endpackage : aasw_pkg

// *** design/aasw_cycle.sv ***
`timescale 1ns/1ns
`include "aasw_defs.svh"

module aasw_cycle (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clr,
  input  wire logic                     start,
  input  wire logic                     internal,
  input  wire logic                     three_state,
  input  wire logic [1:0]               prog_waits,
  input  wire logic                     wait_req,
  input  wire logic                     wr,
  input  wire logic [`AASW_ADDR_W-1:0] addr,
  input  wire logic [7:0]               wdata,
  input  wire logic [7:0]               ext_data_i,
  output logic                          busy,
  output logic                          done,
  output logic [7:0]                    rdata,
  output logic [`AASW_ADDR_W-1:0]      ext_addr,
  output logic                          ext_as_n,
  output logic                          ext_rd_n,
  output logic                          ext_wr_n,
  output logic [7:0]                    ext_data_o,
  output logic                          ext_data_oe
);

  aasw_pkg::aasw_state_t state_ff;
  logic [1:0]            cnt_ff;
  logic                  three_ff;
  logic [1:0]            waits_ff;
  logic                  wr_ff;
  logic                  done_ff;
  logic [7:0]            rdata_ff;
  logic [`AASW_ADDR_W-1:0] addr_ff;
  logic [7:0]            wdata_ff;
  logic                  ext_act;
  logic                  finish;

  // last state of an access: 2-state ends in T2, 3-state in T3
  assign finish = (state_ff == aasw_pkg::AASW_T3) ||
                  (state_ff == aasw_pkg::AASW_T2 && !three_ff) ||
                  (state_ff == aasw_pkg::AASW_TI && cnt_ff == 2'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= aasw_pkg::AASW_IDLE;
      cnt_ff   <= 2'h0;
    end else if (clr) begin
      state_ff <= aasw_pkg::AASW_IDLE;
      cnt_ff   <= 2'h0;
    end else begin
      case (state_ff)
        aasw_pkg::AASW_IDLE: begin
          if (start && internal) begin
            state_ff <= aasw_pkg::AASW_TI;
            cnt_ff   <= `AASW_INT_STATES - 2'h1;
          end else if (start) begin
            state_ff <= aasw_pkg::AASW_T1;
          end
        end
        aasw_pkg::AASW_T1: state_ff <= aasw_pkg::AASW_T2;
        aasw_pkg::AASW_T2: begin
          if (!three_ff) begin
            state_ff <= aasw_pkg::AASW_IDLE;
          end else if (waits_ff != 2'h0) begin
            state_ff <= aasw_pkg::AASW_TW;
            cnt_ff   <= waits_ff - 2'h1;
          end else if (wait_req) begin
            state_ff <= aasw_pkg::AASW_TW;
            cnt_ff   <= 2'h0;
          end else begin
            state_ff <= aasw_pkg::AASW_T3;
          end
        end
        aasw_pkg::AASW_TW: begin
          if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
          end else if (!wait_req) begin
            state_ff <= aasw_pkg::AASW_T3;
          end
        end
        aasw_pkg::AASW_T3: state_ff <= aasw_pkg::AASW_IDLE;
        aasw_pkg::AASW_TI: begin
          if (cnt_ff == 2'h0) begin
            state_ff <= aasw_pkg::AASW_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
        default: state_ff <= aasw_pkg::AASW_IDLE;
      endcase
    end
  end

  // access settings latched at start, held for the whole cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      three_ff <= 1'b0;
      waits_ff <= 2'h0;
      wr_ff    <= 1'b0;
      addr_ff  <= '0;
      wdata_ff <= 8'h00;
    end else if (start && state_ff == aasw_pkg::AASW_IDLE && !clr) begin
      three_ff <= three_state;
      waits_ff <= three_state ? prog_waits : 2'h0;
      wr_ff    <= wr;
      addr_ff  <= internal ? addr_ff : addr;
      wdata_ff <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff  <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      done_ff <= finish && !clr;
      if (finish && !wr_ff && state_ff != aasw_pkg::AASW_TI) begin
        rdata_ff <= ext_data_i;
      end
    end
  end

  // strobes and address held through every wait state
  assign ext_act     = state_ff != aasw_pkg::AASW_IDLE && state_ff != aasw_pkg::AASW_TI;
  assign ext_as_n    = !ext_act;
  assign ext_rd_n    = !(ext_act && !wr_ff);
  assign ext_wr_n    = !(ext_act && wr_ff && state_ff != aasw_pkg::AASW_T1);
  assign ext_data_oe = ext_act && wr_ff;
  assign ext_data_o  = wdata_ff;
  assign ext_addr    = addr_ff;
  assign busy        = state_ff != aasw_pkg::AASW_IDLE;
  assign done        = done_ff;
  assign rdata       = rdata_ff;

endmodule : aasw_cycle

// *** design/aasw_top.sv ***
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "aasw_defs.svh"

module aasw_top (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [4:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     mode_advanced,
  input  wire logic                     hw_standby_n,
  input  wire logic                     manual_reset_n,
  input  wire logic                     acc_req,
  input  wire logic                     acc_internal,
  input  wire logic                     acc_wr,
  input  wire logic [`AASW_ADDR_W-1:0] acc_addr,
  input  wire logic [7:0]               acc_wdata,
  output logic                          acc_done,
  output logic [7:0]                    acc_rdata,
  output logic [`AASW_ADDR_W-1:0]      ext_addr,
  output logic                          ext_as_n,
  output logic                          ext_rd_n,
  output logic                          ext_wr_n,
  input  wire logic                     ext_wait_n,
  input  wire logic [7:0]               ext_data_i,
  output logic [7:0]                    ext_data_o,
  output logic                          ext_data_oe
);

  logic [7:0]            ast_ff;
  logic [7:0]            wup_ff;
  logic [7:0]            wlo_ff;
  logic [3:0]            pin_s1_ff;
  logic [3:0]            pin_s2_ff;
  logic [3:0]            pin_s3_ff;
  logic [3:0]            pin_q_ff;
  logic [3:0]            pin_agree;
  logic                  resp_ff;
  logic [31:0]           rdata_ff;
  logic                  bus_req;
  logic                  wr_take;
  logic                  standby;
  logic                  man_reset;
  logic                  adv_mode;
  logic                  wait_req;
  logic                  cyc_busy;
  logic                  cyc_done;
  logic                  cyc_start;
  logic                  cyc_clr;
  aasw_pkg::aasw_area_t  cur_area;
  logic                  cur_three;
  logic [1:0]            cur_waits;
  aasw_pkg::aasw_area_t  last_area_ff;
  logic                  last_three_ff;
  logic [1:0]            last_waits_ff;
  logic [7:0]            status;
  logic [7:0]            nxt_rdata;
  logic                  sel_ast;
  logic                  sel_wup;
  logic                  sel_wlo;
  logic                  sel_stat;
  logic                  wr_ast;
  logic                  wr_wup;
  logic                  wr_wlo;

  // area of an address: three top bits in advanced mode, else area 0
  function automatic aasw_pkg::aasw_area_t area_of(
    input logic [`AASW_ADDR_W-1:0] a,
    input logic                    adv
  );
    if (adv) begin
      return a[`AASW_AREA_MSB:`AASW_AREA_LSB];
    end
    return 3'h0;
  endfunction : area_of

  // 2-bit wait field of an area across upper and lower registers
  function automatic logic [1:0] wait_field(
    input logic [7:0]           up,
    input logic [7:0]           lo,
    input aasw_pkg::aasw_area_t area
  );
    logic [15:0] both;
    both = {up, lo};
    return both[{area, 1'b0} +: 2];
  endfunction : wait_field

  // register index match for a word-aligned byte address
  function automatic logic hit(
    input logic [4:0] adr,
    input logic [4:0] reg_adr
  );
    return adr == reg_adr;
  endfunction : hit

  // program waits only count in a three-state area
  function automatic logic [1:0] eff_waits(
    input logic       three,
    input logic [1:0] waits
  );
    if (three) begin
      return waits;
    end
    return 2'h0;
  endfunction : eff_waits

  // status word: live busy and mode, then the last external access
  function automatic logic [7:0] status_word(
    input logic                 busy,
    input logic                 adv,
    input aasw_pkg::aasw_area_t area,
    input logic                 three,
    input logic [1:0]           waits
  );
    logic [7:0] s;
    s = 8'h00;
    s[`AASW_ST_BUSY] = busy;
    s[`AASW_ST_ADV] = adv;
    s[`AASW_ST_AREA_MSB:`AASW_ST_AREA_LSB] = area;
    s[`AASW_ST_THREE] = three;
    s[`AASW_ST_WAIT_MSB:`AASW_ST_WAIT_LSB] = waits;
    return s;
  endfunction : status_word

  // pin inputs: three stages, a change counts when stage 2 and 3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= `AASW_PIN_RST;
      pin_s2_ff <= `AASW_PIN_RST;
      pin_s3_ff <= `AASW_PIN_RST;
    end else begin
      pin_s1_ff <= {mode_advanced, manual_reset_n, hw_standby_n, ext_wait_n};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  assign pin_agree = ~(pin_s2_ff ^ pin_s3_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q_ff <= `AASW_PIN_RST;
    end else begin
      pin_q_ff <= (pin_agree & pin_s2_ff) | (~pin_agree & pin_q_ff);
    end
  end

  assign wait_req  = !pin_q_ff[0];
  assign standby   = !pin_q_ff[1];
  assign man_reset = !pin_q_ff[2];
  assign adv_mode  = pin_q_ff[3];

  // Avalon slave: one wait cycle, answer in the second cycle
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !resp_ff;
  assign wr_take         = avs_write && resp_ff && avs_byteenable[0];

  // one select per register, shared by the write and read paths;
  // a standby clear still wins over a write landing in the same cycle
  assign sel_ast  = hit(avs_address, `AASW_ADR_AST);
  assign sel_wup  = hit(avs_address, `AASW_ADR_WUP);
  assign sel_wlo  = hit(avs_address, `AASW_ADR_WLO);
  assign sel_stat = hit(avs_address, `AASW_ADR_STAT);
  assign wr_ast   = wr_take && sel_ast;
  assign wr_wup   = wr_take && sel_wup;
  assign wr_wlo   = wr_take && sel_wlo;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_ff <= 1'b0;
    end else begin
      resp_ff <= bus_req && !resp_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ast_ff <= `AASW_RST_AST;
    end else if (standby) begin
      ast_ff <= `AASW_RST_AST;
    end else if (wr_ast) begin
      ast_ff <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wup_ff <= `AASW_RST_WUP;
    end else if (standby) begin
      wup_ff <= `AASW_RST_WUP;
    end else if (wr_wup) begin
      wup_ff <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wlo_ff <= `AASW_RST_WLO;
    end else if (standby) begin
      wlo_ff <= `AASW_RST_WLO;
    end else if (wr_wlo) begin
      wlo_ff <= avs_writedata[7:0];
    end
  end

  assign status = status_word(cyc_busy, adv_mode, last_area_ff, last_three_ff, last_waits_ff);

  // unmapped addresses read as zero, writes to them are dropped
  always_comb begin
    nxt_rdata = 8'h00;
    if (sel_ast) begin
      nxt_rdata = ast_ff;
    end else if (sel_wup) begin
      nxt_rdata = wup_ff;
    end else if (sel_wlo) begin
      nxt_rdata = wlo_ff;
    end else if (sel_stat) begin
      nxt_rdata = status;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !resp_ff) begin
      rdata_ff <= {24'h00_0000, nxt_rdata};
    end
  end

  assign avs_readdata = rdata_ff;

  // per-access settings; normal mode only looks at area 0
  assign cur_area  = area_of(acc_addr, adv_mode);
  assign cur_three = ast_ff[cur_area];
  assign cur_waits = wait_field(wup_ff, wlo_ff, cur_area);

  // manual reset and standby abort a cycle; only standby touches registers
  assign cyc_clr   = man_reset || standby;
  assign cyc_start = acc_req && !cyc_busy && !cyc_done && !cyc_clr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_area_ff  <= 3'h0;
      last_three_ff <= 1'b0;
      last_waits_ff <= 2'h0;
    end else if (cyc_start && !acc_internal) begin
      last_area_ff  <= cur_area;
      last_three_ff <= cur_three;
      last_waits_ff <= eff_waits(cur_three, cur_waits);
    end
  end

  aasw_cycle u_cycle (
    .clk         (clk),
    .rst_n       (rst_n),
    .clr         (cyc_clr),
    .start       (cyc_start),
    .internal    (acc_internal),
    .three_state (cur_three),
    .prog_waits  (cur_waits),
    .wait_req    (wait_req),
    .wr          (acc_wr),
    .addr        (acc_addr),
    .wdata       (acc_wdata),
    .ext_data_i  (ext_data_i),
    .busy        (cyc_busy),
    .done        (cyc_done),
    .rdata       (acc_rdata),
    .ext_addr    (ext_addr),
    .ext_as_n    (ext_as_n),
    .ext_rd_n    (ext_rd_n),
    .ext_wr_n    (ext_wr_n),
    .ext_data_o  (ext_data_o),
    .ext_data_oe (ext_data_oe)
  );

  assign acc_done = cyc_done;

endmodule : aasw_top

// *** test/aasw_props.sv ***
`timescale 1ns/1ns
module aasw_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        hw_standby_n,
  input wire logic        manual_reset_n,
  input wire logic        acc_req,
  input wire logic        acc_internal,
  input wire logic        acc_done,
  input wire logic [23:0] ext_addr,
  input wire logic        ext_as_n,
  input wire logic        ext_rd_n,
  input wire logic        ext_wr_n,
  input wire logic        ext_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_int_take;
    $rose(acc_req) && acc_internal && !acc_done;
  endsequence
  sequence s_int_end;
    ##1 !acc_done ##1 !acc_done ##1 acc_done;
  endsequence
  AST_ONE_WAIT: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus wait too long");
  AST_UPPER_ZERO: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_INT_QUIET: assert property (
    acc_req && acc_internal |-> ext_as_n && ext_rd_n && ext_wr_n) else $error("strobe on internal");
  AST_INT_LAT: assert property (
    s_int_take |-> s_int_end) else $error("internal access length wrong");
  AST_ADDR_HELD: assert property (
    !ext_as_n && !$past(ext_as_n) |-> $stable(ext_addr)) else $error("address moved in cycle");
  AST_DONE_ENDS: assert property (
    $rose(ext_as_n) && manual_reset_n && hw_standby_n |-> acc_done) else $error("cycle ended early");
  AST_WR_DRIVE: assert property (
    !ext_wr_n |-> ext_data_oe && ext_rd_n) else $error("write strobe without data");
  AST_TWO_STATES: assert property (
    $fell(ext_as_n) |-> !ext_as_n[*2]) else $error("cycle shorter than two states");
  AST_DONE_PULSE: assert property (
    acc_done |=> !acc_done) else $error("done longer than one cycle");
endmodule : aasw_props

bind aasw_top aasw_props i_aasw_props (.*);

// *** test/aasw_ext_mem.sv ***
`timescale 1ns/1ns
module aasw_ext_mem (
  input  wire logic        clk,
  input  wire logic [23:0] ext_addr,
  input  wire logic        ext_as_n,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic [7:0]  ext_data_o,
  input  wire logic        ext_data_oe,
  input  wire logic [3:0]  stall,
  output logic [7:0]       ext_data_i,
  output logic             ext_wait_n
);
  logic [7:0] mem [256];
  logic [7:0] last_ff;
  logic [3:0] st_ff;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    last_ff = 8'h00;
    st_ff = 4'h0;
  end
  // no pull on the data bus: flipped value when not read
  assign ext_data_i = ext_rd_n ? ~last_ff : mem[ext_addr[7:0]];
  // wait only while a cycle runs
  assign ext_wait_n = ext_as_n || (st_ff == 4'h0);
  always @(posedge clk) begin
    if (!ext_wr_n && ext_data_oe) mem[ext_addr[7:0]] <= ext_data_o;
    if (!ext_rd_n) last_ff <= mem[ext_addr[7:0]];
    if (ext_as_n) st_ff <= stall;
    else if (st_ff != 4'h0) st_ff <= st_ff - 4'h1;
  end
endmodule : aasw_ext_mem

// *** test/aasw_top_tb.sv ***
`timescale 1ns/1ns
`include "aasw_defs.svh"
module aasw_top_tb;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable, stall;
  logic        mode_advanced, hw_standby_n, manual_reset_n;
  logic        acc_req, acc_internal, acc_wr, acc_done;
  logic [23:0] acc_addr, ext_addr;
  logic [7:0]  acc_wdata, acc_rdata, ext_data_i, ext_data_o;
  logic        ext_as_n, ext_rd_n, ext_wr_n, ext_wait_n, ext_data_oe;
  logic [7:0]  asts [2];
  int          err_total, checks_done, lat, w;

  aasw_top     i_aasw_top (.*);
  aasw_ext_mem i_aasw_ext_mem (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    // request held until the rising edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        err_total++;
        end_of_test();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(rd, {24'h0, exp});
  endtask : rdchk

  task automatic acc(input logic in, input logic wr, input logic [23:0] a,
                     input logic [7:0] d);
    lat = -1;
    @(posedge clk);
    acc_req <= 1'b1;
    acc_internal <= in;
    acc_wr <= wr;
    acc_addr <= a;
    acc_wdata <= d;
    do begin
      @(posedge clk);
      lat++;
      if (lat > 40) begin
        err_total++;
        end_of_test();
      end
    end while (acc_done !== 1'b1);
    acc_req <= 1'b0;
  endtask : acc

  task automatic setregs(input logic [7:0] a, input logic [7:0] u, input logic [7:0] l);
    bus(1'b1, `AASW_ADR_AST, a, 4'hf);
    bus(1'b1, `AASW_ADR_WUP, u, 4'hf);
    bus(1'b1, `AASW_ADR_WLO, l, 4'hf);
  endtask : setregs

  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, acc_req, acc_internal, acc_wr, mode_advanced} = 6'h0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {acc_addr, acc_wdata, stall} = '0;
    hw_standby_n = 1'b1;
    manual_reset_n = 1'b1;
    err_total = 0;
    checks_done = 0;
    asts[0] = 8'h5a;
    asts[1] = 8'hff;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`AASW_ADR_AST, 8'hff);
    rdchk(`AASW_ADR_WUP, 8'hff);
    rdchk(`AASW_ADR_WLO, 8'hff);
    rdchk(5'h00, 8'h00);
    bus(1'b1, 5'h14, 8'h77, 4'hf);
    rdchk(5'h14, 8'h00);
    setregs(8'ha5, 8'h1b, 8'he4);
    bus(1'b1, `AASW_ADR_AST, 8'h00, 4'h0);
    rdchk(`AASW_ADR_AST, 8'ha5);
    rdchk(`AASW_ADR_WUP, 8'h1b);
    rdchk(`AASW_ADR_WLO, 8'he4);
    // advanced mode: every area, every wait code
    mode_advanced <= 1'b1;
    repeat (6) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      setregs(asts[k], 8'he4, 8'h1b);
      for (int ar = 0; ar < 8; ar++) begin
        w = int'((16'he41b >> (2 * ar)) & 16'h3);
        acc(1'b0, 1'b0, {3'(ar), 13'h0, 8'(ar + 16)}, 8'h00);
        chk(lat, asts[k][ar] ? 4 + w : 3);
        chk(acc_rdata, 8'(ar + 16) ^ 8'h5a);
      end
    end
    // last access: area 7, three-state, three waits, advanced mode
    rdchk(`AASW_ADR_STAT, 8'hfe);
    acc(1'b1, 1'b0, 24'h000040, 8'h00);
    chk(lat, 3);
    // external wait pin against three- and two-state
    setregs(8'hff, 8'hff, 8'hff);
    stall <= 4'h8;
    acc(1'b0, 1'b0, 24'h000021, 8'h00);
    chk(lat > 7, 1);
    bus(1'b1, `AASW_ADR_AST, 8'hfe, 4'hf);
    acc(1'b0, 1'b0, 24'h000021, 8'h00);
    chk(lat, 3);
    stall <= 4'h0;
    acc(1'b0, 1'b1, 24'h000033, 8'hc3);
    acc(1'b0, 1'b0, 24'h000033, 8'h00);
    chk(acc_rdata, 8'hc3);
    // normal mode: only area 0 settings count
    mode_advanced <= 1'b0;
    repeat (6) @(posedge clk);
    acc(1'b0, 1'b0, 24'he00010, 8'h00);
    chk(lat, 3);
    setregs(8'h01, 8'h00, 8'hfd);
    acc(1'b0, 1'b0, 24'he00010, 8'h00);
    chk(lat, 5);
    // last access: area 0, three-state, one wait, normal mode
    rdchk(`AASW_ADR_STAT, 8'h60);
    setregs(8'hfe, 8'h00, 8'hfc);
    acc(1'b0, 1'b0, 24'he00010, 8'h00);
    chk(lat, 3);
    manual_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    manual_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk(`AASW_ADR_AST, 8'hfe);
    rdchk(`AASW_ADR_WLO, 8'hfc);
    hw_standby_n <= 1'b0;
    repeat (6) @(posedge clk);
    hw_standby_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk(`AASW_ADR_AST, 8'hff);
    rdchk(`AASW_ADR_WUP, 8'hff);
    rdchk(`AASW_ADR_WLO, 8'hff);
    end_of_test();
  end
endmodule : aasw_top_tb
